// ### hw/usx_core.sv
/*
  serial transmitter-receiver core: mode and command ports, status
  byte, async/sync receiver with a 32-word buffer, transmitter with
  one-word holding buffer, modem lines. assumes host strobes are
  one-cycle pulses on clk and serial pins are asynchronous.
*/
// What this block does
// - status byte copies the flag pins and the dsr level for polling; transmit free shows the buffer alone
// - a status bit follows its condition within 16 clock periods
// - flag pins update within 28 clock periods of their event
// - receive gate only masks the character-available pin; reception continues
// - error clear resets all error flags even with receive gate off
// - external sync option disables internal sync character detection
// - external sync flop follows input high, clears on status read after
// - transmit buffer free pin asserts within 8 periods of last bit centre
// - character available pin asserts within 24 periods of last bit centre
// - internal sync found asserts within 24 periods of receive clock rise
// - transmitter idle asserts within 20 periods of final data bit centre
// - transmit gate, dtr and rts follow a command within 8 periods
// - error clear command resets parity, overrun, framing at once; not kept
// - status read clears the sync found bit
// - hunt fills receiver with ones, searches sync, no parity, until found
`timescale 1ns/1ps
`default_nettype none

module usx_core import usx_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_mode_wr,
  input wire logic [7:0] host_mode,
  input wire logic host_cmd_wr,
  input wire logic [7:0] host_cmd,
  input wire logic host_data_wr,
  input wire logic [7:0] host_data,
  input wire logic host_data_rd,
  input wire logic host_status_rd,
  input wire logic [7:0] sync_char1,
  input wire logic [7:0] sync_char2,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic sync_in,
  output logic [7:0] rd_data,
  output logic [7:0] status,
  output logic txd,
  output logic dtr_n,
  output logic rts_n,
  output logic tx_buffer_free,
  output logic rx_char_available,
  output logic tx_shifter_idle,
  output logic sync_found
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [PIN_SYNC_W-1:0] pin_lvl;
  logic [PIN_SYNC_W-1:0] pin_rise;
  logic [PIN_SYNC_W-1:0] pin_fall;

  usx_sync #(.W(PIN_SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({tx_bit_clock, rx_bit_clock, rxd, cts_n, dsr_n, sync_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic tx_tick;
  logic rx_tick;
  logic rxd_s;
  logic cts_s;
  logic dsr_s;
  logic sync_in_s;
  // transmit data moves on the falling edge, receive samples on the rising one
  assign tx_tick = pin_fall[5];
  assign rx_tick = pin_rise[4];
  assign rxd_s = pin_lvl[3];
  assign cts_s = ~pin_lvl[2];
  assign dsr_s = ~pin_lvl[1];
  assign sync_in_s = pin_lvl[0];

  // ----------------------------------------
  // mode and command
  // ----------------------------------------
  logic [7:0] mode_r;
  logic [7:0] cmd_r;
  logic mode_ok_r;
  logic soft_rst;
  logic clr;
  logic err_clr;

  assign soft_rst = host_cmd_wr & host_cmd[CMD_SOFT_RST];
  assign clr = rst | soft_rst;
  assign err_clr = host_cmd_wr & host_cmd[CMD_ERR_CLR];

  // receiver and transmitter stay idle until a mode byte arrives after any reset
  always_ff @(posedge clk) begin
    if (clr) begin
      mode_r <= MODE_RST;
      mode_ok_r <= 1'b0;
    end else if (host_mode_wr) begin
      mode_r <= host_mode;
      mode_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      cmd_r <= CMD_RST;
    end else if (host_cmd_wr) begin
      cmd_r <= host_cmd & CMD_KEEP_MASK;
    end
  end

  logic sync_mode;
  logic ext_sync;
  logic par_en;
  logic par_even;
  logic [6:0] factor;
  logic [3:0] len;
  logic [3:0] nbits;
  logic [7:0] stop_ticks;
  logic hunt_go;

  assign sync_mode = mode_r[MODE_BAUD_LSB +: 2] == BAUD_SYNC;
  assign ext_sync = sync_mode & mode_r[MODE_EXT_SYNC];
  assign par_en = mode_r[MODE_PAR_EN];
  assign par_even = mode_r[MODE_PAR_EVEN];
  assign factor = usx_factor(mode_r[MODE_BAUD_LSB +: 2]);
  assign len = usx_len(mode_r[MODE_LEN_LSB +: 2]);
  assign nbits = len + {3'h0, par_en};
  assign stop_ticks = usx_stop_ticks(mode_r[MODE_BAUD_LSB +: 2], mode_r[MODE_STOP_LSB +: 2]);
  assign hunt_go = host_cmd_wr & host_cmd[CMD_HUNT] & sync_mode & mode_ok_r;

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  usx_rx_st_t rx_st_r;
  logic [6:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [8:0] rx_sh_in;
  logic [8:0] rx_word;
  logic [8:0] rx_tail;
  logic [7:0] rx_data;
  logic rx_sample;
  logic rx_push;
  logic rx_pe_now;
  logic rx_fe_now;
  logic hit1;
  logic hit2;
  logic int_hit;

  assign rx_sh_in = {rxd_s, rx_sh_r[8:1]};
  assign rx_sample = rx_tick & (rx_cnt_r == 7'h00);
  assign rx_word = usx_just((rx_st_r == RX_STOP) ? rx_sh_r : rx_sh_in, nbits);
  assign rx_data = rx_word[7:0] & usx_mask(len);
  assign rx_pe_now = par_en & (rx_word[len] != usx_parity(rx_data, par_even));
  assign rx_fe_now = (rx_st_r == RX_STOP) & ~rxd_s;
  assign rx_tail = usx_just(rx_sh_in, len);
  assign hit1 = rx_tail[7:0] == (sync_char1 & usx_mask(len));
  assign hit2 = rx_tail[7:0] == (sync_char2 & usx_mask(len));
  // characters are assembled and stored whatever the receive gate says
  assign rx_push = rx_sample & ((rx_st_r == RX_STOP) |
    (rx_st_r == RX_BITS & sync_mode & rx_bit_r == nbits - 4'h1));
  // only the internal detector when the external option is off
  assign int_hit = rx_tick & ~ext_sync & ((rx_st_r == RX_HUNT & mode_r[MODE_ONE_SYNC] & hit1) |
    (rx_st_r == RX_SYNC2 & rx_bit_r == len - 4'h1 & hit2));

  always_ff @(posedge clk) begin
    if (clr || !mode_ok_r) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 7'h00;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h1ff;
    end else if (hunt_go) begin
      rx_st_r <= RX_HUNT;
      rx_sh_r <= 9'h1ff;
      rx_bit_r <= 4'h0;
      rx_cnt_r <= 7'h00;
    end else begin
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_bit_r <= 4'h0;
          if (sync_mode) begin
            rx_st_r <= RX_HUNT;
            rx_sh_r <= 9'h1ff;
          end else if (rx_tick && !rxd_s) begin
            // 1x has no half-bit wait: the detecting edge is the centre
            rx_st_r <= (factor == 7'h01) ? RX_BITS : RX_START;
            rx_cnt_r <= (factor == 7'h01) ? factor - 7'h01 : {1'b0, factor[6:1]} - 7'h01;
          end
        end
        RX_START: begin
          if (rx_tick && rx_cnt_r != 7'h00) begin
            rx_cnt_r <= rx_cnt_r - 7'h01;
          end else if (rx_tick) begin
            rx_st_r <= rxd_s ? RX_IDLE : RX_BITS;
            rx_cnt_r <= factor - 7'h01;
          end
        end
        RX_HUNT: begin
          // no parity check while searching
          if (rx_tick) begin
            rx_sh_r <= rx_sh_in;
            rx_bit_r <= 4'h0;
            if (ext_sync && sync_in_s) begin
              rx_st_r <= RX_BITS;
            end else if (!ext_sync && hit1) begin
              rx_st_r <= mode_r[MODE_ONE_SYNC] ? RX_BITS : RX_SYNC2;
            end
          end
        end
        RX_SYNC2: begin
          if (rx_tick) begin
            rx_sh_r <= rx_sh_in;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == len - 4'h1) begin
              rx_bit_r <= 4'h0;
              rx_st_r <= hit2 ? RX_BITS : RX_HUNT;
            end
          end
        end
        RX_BITS: begin
          if (rx_sample) begin
            rx_sh_r <= rx_sh_in;
            rx_cnt_r <= factor - 7'h01;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == nbits - 4'h1) begin
              rx_bit_r <= 4'h0;
              rx_st_r <= sync_mode ? RX_BITS : RX_STOP;
            end
          end else if (rx_tick) begin
            rx_cnt_r <= rx_cnt_r - 7'h01;
          end
        end
        RX_STOP: begin
          if (rx_tick && rx_cnt_r != 7'h00) begin
            rx_cnt_r <= rx_cnt_r - 7'h01;
          end else if (rx_tick) begin
            rx_st_r <= RX_IDLE;
          end
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_dout;

  assign fifo_pop = host_data_rd & fifo_valid;

  // a full buffer refuses the new character, which becomes an overrun
  usx_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(clr),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_dout)
  );

  always_ff @(posedge clk) begin
    if (clr) begin
      rd_data <= 8'h00;
    end else if (fifo_pop) begin
      rd_data <= fifo_dout;
    end
  end

  // ----------------------------------------
  // error and sync flags
  // ----------------------------------------
  logic pe_r;
  logic oe_r;
  logic fe_r;

  // a new error in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (clr) begin
      pe_r <= 1'b0;
      oe_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      pe_r <= (pe_r & ~err_clr) | (rx_push & rx_pe_now);
      oe_r <= (oe_r & ~err_clr) | (rx_push & ~fifo_in_ready);
      fe_r <= (fe_r & ~err_clr) | (rx_push & rx_fe_now);
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      sync_found <= 1'b0;
    end else if (ext_sync) begin
      sync_found <= sync_in_s | (sync_found & ~host_status_rd);
    end else begin
      sync_found <= int_hit | (sync_found & ~host_status_rd);
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  usx_tx_st_t tx_st_r;
  logic [7:0] tx_buf_r;
  logic tx_full_r;
  logic tx_fill_r;
  logic txd_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_nb_r;
  logic [7:0] tx_cnt_r;
  logic [7:0] tx_d;
  logic [8:0] tx_body;
  logic [9:0] tx_frame;
  logic tx_have;
  logic tx_fill_ok;
  logic tx_end;
  logic tx_go;

  // a written character still goes out after the gate is dropped
  assign tx_have = tx_full_r & cts_s;
  assign tx_fill_ok = sync_mode & cmd_r[CMD_TX_GATE] & cts_s;
  assign tx_d = (tx_full_r ? tx_buf_r : sync_char1) & usx_mask(len);
  assign tx_body = {1'b0, tx_d} | ((par_en & usx_parity(tx_d, par_even)) ? 9'(9'h001 << len) : 9'h000);
  assign tx_frame = sync_mode ? {1'b0, tx_body} : {tx_body, 1'b0};
  assign tx_end = tx_tick & (tx_cnt_r == 8'h00) &
    ((tx_st_r == TX_BITS & tx_nb_r == 4'h0 & sync_mode) | tx_st_r == TX_STOP);
  assign tx_go = mode_ok_r & ((tx_tick & tx_st_r == TX_IDLE) | tx_end) & (tx_have | tx_fill_ok);

  always_ff @(posedge clk) begin
    if (clr || !mode_ok_r) begin
      tx_st_r <= TX_IDLE;
      txd_r <= 1'b1;
      tx_sh_r <= 9'h000;
      tx_nb_r <= 4'h0;
      tx_cnt_r <= 8'h00;
      tx_fill_r <= 1'b0;
    end else if (tx_go) begin
      tx_st_r <= TX_BITS;
      txd_r <= tx_frame[0];
      tx_sh_r <= tx_frame[9:1];
      tx_nb_r <= nbits - {3'h0, sync_mode};
      tx_cnt_r <= {1'b0, factor} - 8'h01;
      tx_fill_r <= ~tx_have;
    end else if (tx_end) begin
      tx_st_r <= TX_IDLE;
      txd_r <= 1'b1;
      tx_fill_r <= 1'b0;
    end else if (tx_tick) begin
      unique case (tx_st_r)
        TX_IDLE: begin
          txd_r <= 1'b1;
        end
        TX_BITS: begin
          if (tx_cnt_r != 8'h00) begin
            tx_cnt_r <= tx_cnt_r - 8'h01;
          end else if (tx_nb_r != 4'h0) begin
            txd_r <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[8:1]};
            tx_nb_r <= tx_nb_r - 4'h1;
            tx_cnt_r <= {1'b0, factor} - 8'h01;
          end else begin
            tx_st_r <= TX_STOP;
            txd_r <= 1'b1;
            tx_cnt_r <= stop_ticks - 8'h01;
          end
        end
        TX_STOP: begin
          tx_cnt_r <= tx_cnt_r - 8'h01;
        end
        default: begin
          tx_st_r <= TX_IDLE;
        end
      endcase
    end
  end

  // a write in the loading cycle is a fresh character and keeps the buffer full
  always_ff @(posedge clk) begin
    if (clr) begin
      tx_full_r <= 1'b0;
      tx_buf_r <= 8'h00;
    end else if (host_data_wr) begin
      tx_full_r <= 1'b1;
      tx_buf_r <= host_data;
    end else if (tx_go && tx_have) begin
      tx_full_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // pins and status
  // ----------------------------------------
  // stop bits count as empty shifter so the flag is not a whole bit late
  always_ff @(posedge clk) begin
    if (clr) begin
      txd <= 1'b1;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      tx_buffer_free <= 1'b0;
      rx_char_available <= 1'b0;
      tx_shifter_idle <= 1'b1;
    end else begin
      txd <= cmd_r[CMD_BREAK] ? 1'b0 : txd_r;
      dtr_n <= ~cmd_r[CMD_DTR];
      rts_n <= ~cmd_r[CMD_RTS];
      tx_buffer_free <= ~tx_full_r & cts_s & cmd_r[CMD_TX_GATE];
      rx_char_available <= fifo_valid & ~fifo_pop & cmd_r[CMD_RX_GATE];
      tx_shifter_idle <= tx_st_r != TX_BITS | tx_fill_r;
    end
  end

  // frozen while being read so the host sees one coherent byte
  always_ff @(posedge clk) begin
    if (clr) begin
      status <= STATUS_RST;
    end else if (!host_status_rd) begin
      status[ST_TX_FREE] <= ~tx_full_r;
      status[ST_RX_AVAIL] <= rx_char_available;
      status[ST_TX_IDLE] <= tx_shifter_idle;
      status[ST_PAR_ERR] <= pe_r;
      status[ST_OVERRUN] <= oe_r;
      status[ST_FRAME_ERR] <= fe_r;
      status[ST_SYNC] <= sync_found;
      status[ST_DSR] <= dsr_s;
    end
  end

endmodule : usx_core

`default_nettype wire

// ### shared/usx_pkg.sv
/*
  shared constants, state types and helper functions for the serial
  transmitter-receiver core. assumes every design file imports it whole.
*/
`default_nettype none

package usx_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int PIN_SYNC_W = 6;

  // ----------------------------------------
  // mode byte fields
  // ----------------------------------------
  localparam int MODE_BAUD_LSB = 0;
  localparam int MODE_LEN_LSB = 2;
  localparam int MODE_PAR_EN = 4;
  localparam int MODE_PAR_EVEN = 5;
  localparam int MODE_STOP_LSB = 6;
  localparam int MODE_EXT_SYNC = 6;
  localparam int MODE_ONE_SYNC = 7;
  localparam logic [1:0] BAUD_SYNC = 2'h0;
  localparam logic [1:0] BAUD_X1 = 2'h1;
  localparam logic [1:0] BAUD_X16 = 2'h2;
  localparam logic [1:0] BAUD_X64 = 2'h3;
  localparam logic [7:0] MODE_RST = 8'h00;

  // ----------------------------------------
  // command byte fields
  // ----------------------------------------
  localparam int CMD_TX_GATE = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RX_GATE = 2;
  localparam int CMD_BREAK = 3;
  localparam int CMD_ERR_CLR = 4;
  localparam int CMD_RTS = 5;
  localparam int CMD_SOFT_RST = 6;
  localparam int CMD_HUNT = 7;
  localparam logic [7:0] CMD_RST = 8'h00;
  // error clear and soft reset act once and are not kept
  localparam logic [7:0] CMD_KEEP_MASK = 8'haf;

  // ----------------------------------------
  // status byte fields
  // ----------------------------------------
  localparam int ST_TX_FREE = 0;
  localparam int ST_RX_AVAIL = 1;
  localparam int ST_TX_IDLE = 2;
  localparam int ST_PAR_ERR = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_FRAME_ERR = 5;
  localparam int ST_SYNC = 6;
  localparam int ST_DSR = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_HUNT, RX_SYNC2} usx_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} usx_tx_st_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [6:0] usx_factor(input logic [1:0] baud);
    case (baud)
      BAUD_X16: return 7'h10;
      BAUD_X64: return 7'h40;
      default: return 7'h01;
    endcase
  endfunction : usx_factor

  function automatic logic [3:0] usx_len(input logic [1:0] code);
    return 4'h5 + {2'h0, code};
  endfunction : usx_len

  function automatic logic [7:0] usx_mask(input logic [3:0] len);
    return 8'(8'hff >> (4'h8 - len));
  endfunction : usx_mask

  function automatic logic usx_parity(input logic [7:0] d, input logic even);
    return even ? ^d : ~^d;
  endfunction : usx_parity

  // low-justify the newest n bits of a right-shifting register
  function automatic logic [8:0] usx_just(input logic [8:0] v, input logic [3:0] n);
    return 9'(v >> (4'h9 - n));
  endfunction : usx_just

  function automatic logic [7:0] usx_stop_ticks(input logic [1:0] baud, input logic [1:0] code);
    logic [7:0] h;
    logic [6:0] f;
    h = (code == 2'h2) ? 8'h03 : ((code == 2'h3) ? 8'h04 : 8'h02);
    f = usx_factor(baud);
    if (f == 7'h01) begin
      return h >> 1;
    end
    return 8'({1'b0, f[6:1]} * h);
  endfunction : usx_stop_ticks

endpackage : usx_pkg

`default_nettype wire

// ### hw/usx_sync.sv
/*
  two-flop synchroniser for a group of pin inputs, plus a third stage
  for edge finding. assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module usx_sync import usx_pkg::*; #(
  parameter int W = PIN_SYNC_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] prev_r;

  // ----------------------------------------
  // stages; meta_r feeds lvl_r only
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      lvl_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin;
      lvl_r <= meta_r;
      prev_r <= lvl_r;
    end
  end

  assign lvl = lvl_r;
  assign rise = lvl_r & ~prev_r;
  assign fall = ~lvl_r & prev_r;

endmodule : usx_sync

`default_nettype wire

// ### hw/usx_fifo.sv
/*
  synchronous fifo with valid/ready on both sides. assumes one clock;
  out_data is valid whenever out_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none

module usx_fifo import usx_pkg::*; #(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  // ----------------------------------------
  // pointers carry one wrap bit for honest full/empty
  // ----------------------------------------
  assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;
  assign out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end

endmodule : usx_fifo

`default_nettype wire

// ### sim/usx_line.sv
/*
  serial line partner: free-running bit clocks, async 16x frames on rxd,
  and a 16x receiver that samples txd at the bit centres.
  assumes mode 16x, 8 bits, no parity, one stop bit.
*/
`timescale 1ns/1ps
`default_nettype none

module usx_line (
  output logic rx_bit_clock,
  output wire logic tx_bit_clock,
  output logic rxd,
  input wire logic txd
);
  // ----
  // clocks and frames
  // ----
  // 800 ns period, 400 ns each level; odd start keeps it off the clk edges
  initial begin
    rx_bit_clock = 1'b0;
    rxd = 1'b1;
    #13;
    forever #400 rx_bit_clock = ~rx_bit_clock;
  end
  assign tx_bit_clock = rx_bit_clock;

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(negedge rx_bit_clock);
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      repeat (16) @(negedge rx_bit_clock);
    end
  endtask : send

  // start it before the data write so the start edge is not missed
  task automatic recv(output logic [7:0] b);
    wait (txd == 1'b0);
    repeat (8) @(posedge tx_bit_clock);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge tx_bit_clock);
      b[i] = txd;
    end
  endtask : recv
endmodule : usx_line

`default_nettype wire

// ### sim/usx_core_properties.sv
/*
  port checker for usx_core.
  assumes it is bound into every usx_core instance.
*/
`timescale 1ns/1ps
`default_nettype none

module usx_chk import usx_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_cmd_wr,
  input wire logic [7:0] host_cmd,
  input wire logic dsr_n,
  input wire logic [7:0] status,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic tx_buffer_free,
  input wire logic rx_char_available
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // soft reset discards the rest of the command, so it is excluded
  property p_dtr; host_cmd_wr && host_cmd[CMD_DTR] && !host_cmd[CMD_SOFT_RST] |-> ##[1:8] !dtr_n; endproperty
  property p_rts; host_cmd_wr && !host_cmd[CMD_RTS] |-> ##[1:8] rts_n; endproperty
  property p_txg; host_cmd_wr && !host_cmd[CMD_TX_GATE] |-> ##[1:8] !tx_buffer_free; endproperty
  property p_gate; host_cmd_wr && !host_cmd[CMD_RX_GATE] |-> ##[1:8] !rx_char_available; endproperty
  property p_clr; host_cmd_wr && host_cmd[CMD_ERR_CLR] |-> ##[1:16] status[5:3] == 3'h0; endproperty
  property p_mir; $rose(rx_char_available) |-> ##[0:16] status[ST_RX_AVAIL]; endproperty
  property p_dsr; $fell(dsr_n) |-> ##[1:16] status[ST_DSR]; endproperty
  property p_free; $rose(tx_buffer_free) |-> ##[0:16] status[ST_TX_FREE]; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr late");
  a_rts: assert property (p_rts) else $error("rts late");
  a_txg: assert property (p_txg) else $error("tx gate late");
  a_gate: assert property (p_gate) else $error("rx gate ignored");
  a_clr: assert property (p_clr) else $error("errors kept");
  a_mir: assert property (p_mir) else $error("avail status late");
  a_dsr: assert property (p_dsr) else $error("dsr status late");
  a_free: assert property (p_free) else $error("free status late");
  c_avail: cover property ($rose(rx_char_available));
  c_ovr: cover property (status[ST_OVERRUN]);
  c_cmd: cover property (host_cmd_wr);
endmodule : usx_chk

bind usx_core usx_chk u_chk (.*);

`default_nettype wire

// ### sim/tb_top.sv
/*
  self-checking bench for usx_core with a queue model of the receive path.
  assumes package, design, line model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top import usx_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, host_mode_wr = 1'b0, host_cmd_wr = 1'b0, host_data_wr = 1'b0;
  logic host_data_rd = 1'b0, host_status_rd = 1'b0, cts_n = 1'b0, dsr_n = 1'b1, sync_in = 1'b0;
  logic [7:0] host_mode = 8'h00, host_cmd = 8'h00, host_data = 8'h00, sync_char1 = 8'h16, sync_char2 = 8'h16;
  logic tx_bit_clock, rx_bit_clock, rxd, txd, dtr_n, rts_n, tx_buffer_free, rx_char_available;
  logic tx_shifter_idle, sync_found, ovr = 1'b0;
  logic [7:0] rd_data, status, tx_v, tx_got;
  logic [7:0] q[$];
  int error_cnt = 0, tests_run = 0;
  usx_core u_dut (.*);
  usx_line u_line (.*);
  initial begin
    forever #50 clk = ~clk;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge clk);
    {host_mode_wr, host_cmd_wr, host_data_wr} <= {k == 0, k == 1, k == 2};
    {host_mode, host_cmd, host_data} <= {v, v, v};
    @(posedge clk);
    {host_mode_wr, host_cmd_wr, host_data_wr} <= 3'h0;
    repeat (16) @(posedge clk);
  endtask : wr
  task automatic rd();
    @(posedge clk);
    host_data_rd <= 1'b1;
    @(posedge clk);
    host_data_rd <= 1'b0;
    #1 chk("rd_data", q.pop_front(), rd_data);
  endtask : rd
  // a byte that finds the buffer full is dropped, so the model keeps 32
  task automatic rx(input logic [7:0] b);
    u_line.send(b);
    if (q.size() < 32) q.push_back(b);
    else ovr = 1'b1;
  endtask : rx
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    #6000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hf6ab));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("pins", 8'h07, {5'h00, txd, dtr_n, rts_n});
    repeat (6) @(posedge clk);
    wr(0, 8'h4e);
    wr(1, 8'h23);
    chk("pins", 8'h04, {5'h00, txd, dtr_n, rts_n});
    rx(8'($urandom));
    repeat (40) @(posedge clk);
    chk("avail", 8'h00, {7'h00, rx_char_available});
    wr(1, 8'h37);
    chk("avail", 8'h01, {7'h00, rx_char_available});
    rd();
    repeat (33) rx(8'($urandom));
    repeat (40) @(posedge clk);
    chk("overrun", {7'h00, ovr}, {7'h00, status[ST_OVERRUN]});
    while (q.size() > 0) rd();
    chk("avail", 8'h00, {7'h00, rx_char_available});
    wr(1, 8'h37);
    chk("errors", 8'h00, {5'h00, status[5:3]});
    @(posedge clk) dsr_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk("dsr", 8'h01, {7'h00, status[ST_DSR]});
    for (int i = 0; i < 3000 && tx_buffer_free !== 1'b1; i++) @(posedge clk);
    chk("free", 8'h01, {7'h00, tx_buffer_free});
    tx_v = 8'($urandom);
    fork
      u_line.recv(tx_got);
      wr(2, tx_v);
    join
    chk("txd", tx_v, tx_got);
    for (int i = 0; i < 300 && tx_shifter_idle === 1'b1; i++) @(posedge clk);
    for (int i = 0; i < 3000 && {tx_shifter_idle, tx_buffer_free} !== 2'h3; i++) @(posedge clk);
    chk("tx", 8'h07, {5'h00, tx_shifter_idle, tx_buffer_free, txd});
    wr(1, 8'h00);
    chk("pins", 8'h07, {5'h00, txd, dtr_n, rts_n});
    wr(1, 8'h08);
    chk("pins", 8'h03, {5'h00, txd, dtr_n, rts_n});
    // all-ones pattern would match an idle line if internal detection ran
    wr(1, 8'h40);
    sync_char1 <= 8'hff;
    wr(0, 8'hcc);
    chk("sync", 8'h00, {6'h00, sync_found, status[ST_SYNC]});
    @(negedge rx_bit_clock);
    @(posedge clk) sync_in <= 1'b1;
    repeat (30) @(posedge clk);
    chk("sync", 8'h03, {6'h00, sync_found, status[ST_SYNC]});
    sync_in <= 1'b0;
    repeat (10) @(posedge clk);
    chk("sync", 8'h03, {6'h00, sync_found, status[ST_SYNC]});
    host_status_rd <= 1'b1;
    @(posedge clk) host_status_rd <= 1'b0;
    repeat (5) @(posedge clk);
    chk("sync", 8'h00, {6'h00, sync_found, status[ST_SYNC]});
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
